// file: src/fcb_coef_bank.sv
// Coefficient bank for the ninth channel-A tap and first three channel-B taps.
// Assumes an AXI4-Lite master on MCLK; the filter datapath reads the coefficient outputs.
//
// Register access over AXI4-Lite was left to the implementer.
`default_nettype none

module fcb_coef_bank (
    // Clock, reset, enable
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic CE,
    // AXI4-Lite write address
    input wire logic [fcb_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic [2:0] S_AXI_AWPROT,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    // AXI4-Lite write data
    input wire logic [fcb_pkg::DATA_W-1:0] S_AXI_WDATA,
    input wire logic [fcb_pkg::DATA_W/8-1:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    // AXI4-Lite write response
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read address
    input wire logic [fcb_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic [2:0] S_AXI_ARPROT,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    // AXI4-Lite read data
    output logic [fcb_pkg::DATA_W-1:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Filter datapath side
    output fcb_pkg::fcb_coef_s COEF,
    output logic SINGLE_CHAN,
    output logic CHAN_B_ACTIVE
);

    logic aw_held_q;
    logic w_held_q;
    fcb_pkg::fcb_wreq_s wreq_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [fcb_pkg::DATA_W-1:0] rdata_q;
    logic [fcb_pkg::REG_W-1:0] coef_q [fcb_pkg::NUM_TAPS];
    logic single_q;
    logic do_write;
    logic [fcb_pkg::ADDR_W-1:0] w_idx;
    logic [fcb_pkg::ADDR_W-1:0] r_idx;
    logic [fcb_pkg::NUM_TAPS-1:0] w_hit;
    logic w_mode_hit;
    logic [fcb_pkg::REG_W-1:0] w_lanes;
    logic [fcb_pkg::REG_W-1:0] w_mask;
    logic [fcb_pkg::DATA_W-1:0] r_word;
    logic r_ok;

    // Protection bits and the lanes above bit 15 carry no meaning for this bank
    logic unused_prot;
    assign unused_prot = ^{S_AXI_AWPROT, S_AXI_ARPROT,
                           wreq_q.wdata[fcb_pkg::DATA_W-1:fcb_pkg::REG_W],
                           wreq_q.wstrb[fcb_pkg::DATA_W/8-1:fcb_pkg::REG_W/8]};

    // Readiness drops while frozen so no handshake completes unseen
    assign S_AXI_AWREADY = CE && !aw_held_q;
    assign S_AXI_WREADY = CE && !w_held_q;
    assign S_AXI_ARREADY = CE && !rvalid_q;
    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP = bresp_q;
    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RRESP = rresp_q;
    assign S_AXI_RDATA = rdata_q;

    // Address and data are caught in either order, then committed together.
    // One process owns the whole request struct so each field has a single driver.
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            wreq_q <= '0;
        end else if (CE) begin
            if (S_AXI_AWVALID && !aw_held_q) begin
                aw_held_q <= 1'b1;
                wreq_q.awaddr <= S_AXI_AWADDR;
            end else if (do_write) begin
                aw_held_q <= 1'b0;
            end
            if (S_AXI_WVALID && !w_held_q) begin
                w_held_q <= 1'b1;
                wreq_q.wdata <= S_AXI_WDATA;
                wreq_q.wstrb <= S_AXI_WSTRB;
            end else if (do_write) begin
                w_held_q <= 1'b0;
            end
        end
    end

    assign do_write = CE && aw_held_q && w_held_q && !bvalid_q;
    assign w_idx = {2'b00, wreq_q.awaddr[fcb_pkg::ADDR_W-1:2]};
    assign r_idx = {2'b00, S_AXI_ARADDR[fcb_pkg::ADDR_W-1:2]};

    always_comb begin
        w_hit = '0;
        w_mode_hit = 1'b0;
        if (w_idx == fcb_pkg::IDX_CHAN_A_TAP8) begin
            w_hit[fcb_pkg::SLOT_A8] = 1'b1;
        end else if (w_idx == fcb_pkg::IDX_CHAN_B_TAP0) begin
            w_hit[fcb_pkg::SLOT_B0] = 1'b1;
        end else if (w_idx == fcb_pkg::IDX_CHAN_B_TAP1) begin
            w_hit[fcb_pkg::SLOT_B1] = 1'b1;
        end else if (w_idx == fcb_pkg::IDX_CHAN_B_TAP2) begin
            w_hit[fcb_pkg::SLOT_B2] = 1'b1;
        end else if (w_idx == fcb_pkg::IDX_MODE_CTRL) begin
            w_mode_hit = 1'b1;
        end
    end

    // Only the two low byte lanes reach the 16-bit registers
    assign w_lanes = wreq_q.wdata[fcb_pkg::REG_W-1:0];
    assign w_mask = {{8{wreq_q.wstrb[1]}}, {8{wreq_q.wstrb[0]}}};

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            bvalid_q <= 1'b0;
            bresp_q <= fcb_pkg::RESP_OKAY;
        end else if (CE) begin
            if (do_write) begin
                bvalid_q <= 1'b1;
                bresp_q <= (w_hit != '0 || w_mode_hit) ? fcb_pkg::RESP_OKAY
                                                       : fcb_pkg::RESP_SLVERR;
            end else if (S_AXI_BREADY) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Reserved bits 15:12 are writable and kept, as the layout allows
    for (genvar t = 0; t < fcb_pkg::NUM_TAPS; t++) begin : g_tap
        always_ff @(posedge MCLK) begin
            if (RESET) begin
                coef_q[t] <= fcb_pkg::COEF_RESET;
            end else if (CE && do_write && w_hit[t]) begin
                coef_q[t] <= (coef_q[t] & ~w_mask) | (w_lanes & w_mask);
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            single_q <= fcb_pkg::MODE_RESET;
        end else if (CE && do_write && w_mode_hit && wreq_q.wstrb[0]) begin
            single_q <= wreq_q.wdata[fcb_pkg::MODE_SINGLE_BIT];
        end
    end

    // Read mux; coefficient top bit always reads back as zero
    always_comb begin
        r_word = '0;
        r_ok = 1'b1;
        if (r_idx == fcb_pkg::IDX_CHAN_A_TAP8) begin
            r_word[fcb_pkg::REG_W-1:0] = coef_q[fcb_pkg::SLOT_A8];
        end else if (r_idx == fcb_pkg::IDX_CHAN_B_TAP0) begin
            r_word[fcb_pkg::REG_W-1:0] = coef_q[fcb_pkg::SLOT_B0];
        end else if (r_idx == fcb_pkg::IDX_CHAN_B_TAP1) begin
            r_word[fcb_pkg::REG_W-1:0] = coef_q[fcb_pkg::SLOT_B1];
        end else if (r_idx == fcb_pkg::IDX_CHAN_B_TAP2) begin
            r_word[fcb_pkg::REG_W-1:0] = coef_q[fcb_pkg::SLOT_B2];
        end else if (r_idx == fcb_pkg::IDX_MODE_CTRL) begin
            r_word[fcb_pkg::MODE_SINGLE_BIT] = single_q;
        end else begin
            r_ok = 1'b0;
        end
        if (r_idx != fcb_pkg::IDX_MODE_CTRL) begin
            r_word[fcb_pkg::COEF_MSB] = 1'b0;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            rvalid_q <= 1'b0;
            rresp_q <= fcb_pkg::RESP_OKAY;
            rdata_q <= '0;
        end else if (CE) begin
            if (S_AXI_ARVALID && !rvalid_q) begin
                rvalid_q <= 1'b1;
                rresp_q <= r_ok ? fcb_pkg::RESP_OKAY : fcb_pkg::RESP_SLVERR;
                rdata_q <= r_word;
            end else if (S_AXI_RREADY) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // Datapath taps come straight from storage so a write applies from the next sample
    // The single-channel filter reuses the channel-A ninth tap; it is the last of nine
    assign COEF = {
        coef_q[fcb_pkg::SLOT_A8][fcb_pkg::COEF_W-1:0],
        coef_q[fcb_pkg::SLOT_B0][fcb_pkg::COEF_W-1:0],
        coef_q[fcb_pkg::SLOT_B1][fcb_pkg::COEF_W-1:0],
        coef_q[fcb_pkg::SLOT_B2][fcb_pkg::COEF_W-1:0]
    };
    assign SINGLE_CHAN = single_q;
    // Channel-B taps are only meaningful in dual-channel mode
    assign CHAN_B_ACTIVE = !single_q;

endmodule : fcb_coef_bank

`default_nettype wire

// file: src/fcb_pkg.sv
// Constants and carrier types for the equaliser filter coefficient bank.
// Assumes a 32-bit AXI4-Lite register bus and a 200 MHz core clock.
`default_nettype none

package fcb_pkg;

    // Bus geometry
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 32;

    // Register indices as printed; byte address is four times the index
    localparam logic [ADDR_W-1:0] IDX_CHAN_A_TAP8 = 16'h0429;
    localparam logic [ADDR_W-1:0] IDX_CHAN_B_TAP0 = 16'h0448;
    localparam logic [ADDR_W-1:0] IDX_CHAN_B_TAP1 = 16'h044A;
    localparam logic [ADDR_W-1:0] IDX_CHAN_B_TAP2 = 16'h044C;
    localparam logic [ADDR_W-1:0] IDX_MODE_CTRL = 16'h0460;

    // Coefficient register layout
    localparam int unsigned REG_W = 16;
    localparam int unsigned COEF_W = 12;
    localparam int unsigned COEF_MSB = 11;
    localparam logic [REG_W-1:0] COEF_RESET = 16'h0000;
    localparam int unsigned NUM_TAPS = 4;
    localparam int unsigned TAPS_PER_FILTER = 9;

    // Mode control layout
    localparam int unsigned MODE_SINGLE_BIT = 0;
    localparam logic MODE_RESET = 1'b0;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Slot of each tap in the storage array
    typedef enum {
        SLOT_A8,
        SLOT_B0,
        SLOT_B1,
        SLOT_B2
    } fcb_slot_e;

    // Coefficients as the filter datapath sees them
    typedef struct packed {
        logic signed [COEF_W-1:0] chan_a_tap8;
        logic signed [COEF_W-1:0] chan_b_tap0;
        logic signed [COEF_W-1:0] chan_b_tap1;
        logic signed [COEF_W-1:0] chan_b_tap2;
    } fcb_coef_s;

    // Write address and write data channels bundled
    typedef struct packed {
        logic [ADDR_W-1:0] awaddr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W/8-1:0] wstrb;
    } fcb_wreq_s;

endpackage : fcb_pkg

`default_nettype wire

// file: testbench/fcb_coef_bank_chk.sv
// Bus and coefficient-output checks for the coefficient bank.
// Assumes one clock, MCLK, and the synchronous active-high RESET.
`default_nettype none

module fcb_coef_bank_chk (
    // Clock, reset, enable
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic CE,
    // Bus handshakes
    input wire logic S_AXI_AWREADY,
    input wire logic S_AXI_WREADY,
    input wire logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic [fcb_pkg::DATA_W-1:0] S_AXI_RDATA,
    // Filter side
    input wire fcb_pkg::fcb_coef_s COEF,
    input wire logic SINGLE_CHAN,
    input wire logic CHAN_B_ACTIVE
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RESET);

    chk_read_msb_zero: assert property (S_AXI_RVALID |->
        S_AXI_RDATA[11] == 1'b0 && S_AXI_RDATA[31:16] == 16'h0000) else $error("read msb set");
    chk_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read answer late");
    chk_read_holds: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
        S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read data dropped");
    // Reset itself is the antecedent, so this one may not be disabled by it
    chk_reset_clears: assert property (disable iff (1'b0) RESET |=>
        COEF == '0 && !SINGLE_CHAN && !S_AXI_BVALID && !S_AXI_RVALID) else $error("reset");
    chk_mode_pair: assert property (CHAN_B_ACTIVE == !SINGLE_CHAN)
        else $error("mode outputs disagree");
    chk_coef_commit: assert property ($changed(COEF) |-> $rose(S_AXI_BVALID))
        else $error("coefficient moved without a write");
    chk_mode_commit: assert property ($changed(SINGLE_CHAN) |-> $rose(S_AXI_BVALID))
        else $error("mode moved without a write");
    chk_resp_holds: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
        S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write response dropped");
    chk_ce_stalls: assert property (!CE |->
        !S_AXI_AWREADY && !S_AXI_WREADY && !S_AXI_ARREADY) else $error("ready while stalled");
endmodule : fcb_coef_bank_chk

bind fcb_coef_bank fcb_coef_bank_chk u_fcb_coef_bank_chk (.*);

`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking bench for the coefficient bank, driven as an AXI4-Lite master.
// Assumes the bank answers within a few cycles; every wait is bounded.
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic MCLK = 1'b0, RESET = 1'b1, CE = 1'b1;
    logic [15:0] S_AXI_AWADDR = 16'h0000, S_AXI_ARADDR = 16'h0000;
    logic [2:0] S_AXI_AWPROT = 3'h0, S_AXI_ARPROT = 3'h0;
    logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
    logic S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
    logic [31:0] S_AXI_WDATA = 32'h0000_0000, S_AXI_RDATA;
    logic [3:0] S_AXI_WSTRB = 4'h3;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic SINGLE_CHAN, CHAN_B_ACTIVE;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
    fcb_pkg::fcb_coef_s COEF;
    int errors = 0, n_checks = 0;
    // Bit 11 and the reserved nibble are set in every value on purpose
    logic [15:0] adr [4] = '{16'h10A4, 16'h1120, 16'h1128, 16'h1130};
    logic [15:0] val [4] = '{16'hF9A5, 16'hA801, 16'h5FFF, 16'h3C3C};
    logic [1:0] rsp;
    logic [31:0] rd;

    fcb_coef_bank u_fcb_coef_bank (.*);

    initial forever #2.5 MCLK = ~MCLK;

    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done

    task automatic check(input logic [47:0] got, input logic [47:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
            errors++;
        end
    endtask : check

    // Ready waits lag cycles, so the slave must keep its answer standing meanwhile
    task automatic wr(input logic [15:0] a, input logic [15:0] d, input int lag,
                      output logic [1:0] r);
        @(posedge MCLK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= {16'h0000, d};
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= (lag == 0);
        for (int n = 0; n < 40; n++) begin
            @(posedge MCLK);
            if (S_AXI_AWREADY) begin
                S_AXI_AWVALID <= 1'b0;
            end
            if (S_AXI_WREADY) begin
                S_AXI_WVALID <= 1'b0;
            end
            if (S_AXI_BVALID === 1'b1 && S_AXI_BREADY) begin
                r = S_AXI_BRESP;
                S_AXI_BREADY <= 1'b0;
                return;
            end
            if (n + 1 >= lag) begin
                S_AXI_BREADY <= 1'b1;
            end
        end
        $display("BAD %0t write timed out", $time);
        errors++;
        test_done();
    endtask : wr

    task automatic rdr(input logic [15:0] a, input int lag, output logic [31:0] d,
                       output logic [1:0] r);
        @(posedge MCLK);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= (lag == 0);
        for (int n = 0; n < 40; n++) begin
            @(posedge MCLK);
            if (S_AXI_ARREADY) begin
                S_AXI_ARVALID <= 1'b0;
            end
            if (S_AXI_RVALID === 1'b1 && S_AXI_RREADY) begin
                d = S_AXI_RDATA;
                r = S_AXI_RRESP;
                S_AXI_RREADY <= 1'b0;
                return;
            end
            if (n + 1 >= lag) begin
                S_AXI_RREADY <= 1'b1;
            end
        end
        $display("BAD %0t read timed out", $time);
        errors++;
        test_done();
    endtask : rdr

    task automatic t_reset_values;
        check(COEF, 48'h0, "coef at reset");
        check({SINGLE_CHAN, CHAN_B_ACTIVE}, 2'b01, "mode at reset");
        for (int i = 0; i < 4; i++) begin
            rdr(adr[i], i, rd, rsp);
            check({rsp, rd}, 34'h0, "reset readback");
        end
    endtask : t_reset_values

    task automatic t_taps;
        for (int i = 0; i < 4; i++) begin
            wr(adr[i], val[i], 3 * i, rsp);
            check(rsp, fcb_pkg::RESP_OKAY, "tap write response");
        end
        for (int i = 0; i < 4; i++) begin
            check(COEF[47-12*i -: 12], val[i][11:0], "tap output");
            rdr(adr[i], i, rd, rsp);
            check({rsp, rd}, {18'h0, val[i] & 16'hF7FF}, "tap readback");
        end
    endtask : t_taps

    task automatic t_mode;
        wr(fcb_pkg::IDX_MODE_CTRL << 2, 16'h0001, 1, rsp);
        check(rsp, fcb_pkg::RESP_OKAY, "mode write response");
        check({SINGLE_CHAN, CHAN_B_ACTIVE}, 2'b10, "single mode");
        check(COEF[47:36], val[0][11:0], "ninth tap kept");
        rdr(fcb_pkg::IDX_MODE_CTRL << 2, 0, rd, rsp);
        check({rsp, rd}, {fcb_pkg::RESP_OKAY, 32'h0000_0001}, "mode readback");
        wr(fcb_pkg::IDX_MODE_CTRL << 2, 16'h0000, 0, rsp);
        check({SINGLE_CHAN, CHAN_B_ACTIVE}, 2'b01, "dual mode");
    endtask : t_mode

    task automatic t_unmapped;
        wr(16'h1124, 16'hFFFF, 0, rsp);
        check(rsp, fcb_pkg::RESP_SLVERR, "unmapped write");
        check(COEF[23:12], val[2][11:0], "neighbour kept");
        rdr(16'h1124, 0, rd, rsp);
        check({rsp, rd}, {fcb_pkg::RESP_SLVERR, 32'h0}, "unmapped read");
    endtask : t_unmapped

    // Only the low lane is enabled, so bits 15:8 must keep their old value
    task automatic t_strobes;
        S_AXI_WSTRB <= 4'h1;
        wr(adr[3], 16'hFFFF, 0, rsp);
        S_AXI_WSTRB <= 4'h3;
        check(COEF[11:0], {val[3][11:8], 8'hFF}, "low lane only");
        rdr(adr[3], 0, rd, rsp);
        check({rsp, rd}, {18'h0, val[3][15:8] & 8'hF7, 8'hFF}, "lane readback");
    endtask : t_strobes

    // A write offered while frozen must neither complete nor touch a tap
    task automatic t_stall_and_reset;
        logic [47:0] held;
        wr(fcb_pkg::IDX_MODE_CTRL << 2, 16'h0001, 0, rsp);
        @(posedge MCLK);
        held = COEF;
        CE <= 1'b0;
        S_AXI_AWADDR <= adr[3];
        S_AXI_WDATA <= 32'h0000_0123;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        repeat (3) @(posedge MCLK);
        check({S_AXI_AWREADY, S_AXI_WREADY, S_AXI_ARREADY, S_AXI_BVALID}, 4'h0, "stalled");
        check(COEF, held, "frozen taps");
        S_AXI_AWVALID <= 1'b0;
        S_AXI_WVALID <= 1'b0;
        S_AXI_BREADY <= 1'b0;
        CE <= 1'b1;
        RESET <= 1'b1;
        repeat (3) @(posedge MCLK);
        RESET <= 1'b0;
        t_reset_values();
    endtask : t_stall_and_reset

    initial begin
        repeat (16) @(posedge MCLK);
        RESET <= 1'b0;
        t_reset_values();
        t_taps();
        t_mode();
        t_unmapped();
        t_strobes();
        t_stall_and_reset();
        test_done();
    end
endmodule : tb_top

`default_nettype wire
